/* File: logic/phy_syscfg_cfg.svh */
// address map, field positions, reset values and codes of the system config bank
`ifndef PHY_SYSCFG_CFG_SVH
`define PHY_SYSCFG_CFG_SVH
// ==========================================================
// management addressing
`define MGMT_DEVAD 5'h1E
`define GROUP_PORT_ADDR 5'h1F
// ==========================================================
// register addresses inside the management device
`define ADDR_MAC_CFG 16'h882B
`define ADDR_DIAG_CLK 16'h882C
`define ADDR_PKG_TYPE 16'h8C22
`define ADDR_GRP_CTRL 16'h8C30
`define ADDR_PINMUX_A 16'h8C56
`define ADDR_PINMUX_B 16'h8C57
// ==========================================================
// field positions
`define MAC_CLK50_BIT 15
`define MAC_CLKGEN_BIT 14
`define MAC_MEDIA_BIT 8
`define MAC_RMII_BIT 4
`define MAC_RGMII_BIT 0
`define DIAG_EN_BIT 0
`define GRP_EN_BIT 0
`define PMA_LEDB_HI 3
`define PMA_LEDB_LO 1
`define PMA_POL_BIT 0
`define PMB_RX_HI 7
`define PMB_RX_LO 4
`define PMB_TX_HI 3
`define PMB_TX_LO 0
// ==========================================================
// reset values and constant read-back bits
`define DIAG_RESET 16'h0002
`define PMA_RESET 16'h00FE
`define PMA_RSVD 16'h00F0
`define PMB_RESET 16'h00FF
`define LEDB_ROUTE_ON 3'h0
`define LEDB_ROUTE_OFF 3'h7
`define ROUTE_OFF 4'hF
`define ROUTE_PINS 15
`endif

/* File: logic/phy_syscfg_pkg.sv */
// types shared by the system config bank modules
package phy_syscfg_pkg;
    // ==========================================================
    // access sequencer, one-hot
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ACK = 2'b10
    } acc_state_t;
    // ==========================================================
    // one code per routable pin, 1111 means off
    typedef logic [3:0] route_code_t;
    typedef logic [14:0] pin_vec_t;
endpackage

/* File: logic/route_if.sv */
// carrier between the register bank and the pin route decoder
`timescale 1ns/100ps
interface route_if;
    import phy_syscfg_pkg::*;
    route_code_t rx_sel; // receive packet start route
    route_code_t tx_sel; // transmit packet start route
    logic rx_sop; // receive packet start event
    logic tx_sop; // transmit packet start event
    pin_vec_t pin_drv; // level to put on each pin
    pin_vec_t pin_en; // pin taken over by a packet start output
    modport ctrl (output rx_sel, tx_sel, rx_sop, tx_sop, input pin_drv, pin_en);
    modport dec (input rx_sel, tx_sel, rx_sop, tx_sop, output pin_drv, pin_en);
endinterface

/* File: logic/pin_route_decoder.sv */
// decodes the packet start route selectors into per-pin drive and enable
`timescale 1ns/100ps
`include "phy_syscfg_cfg.svh"
module pin_route_decoder
    import phy_syscfg_pkg::*;
#(
    parameter int PINS = `ROUTE_PINS
) (
    // route selectors and events
    route_if.dec rt
);
    // ==========================================================
    // selector decode, shared by both directions
    function automatic logic hits(input route_code_t sel, input int pin);
        hits = (sel == route_code_t'(pin));
    endfunction

    // ==========================================================
    // one slice per pin; code 1111 matches no slice, so it is off
    genvar g;
    generate
        for (g = 0; g < PINS; g = g + 1) begin : g_pin
            // both selectors may name one pin; the events are merged
            assign rt.pin_en[g] = hits(rt.rx_sel, g) | hits(rt.tx_sel, g); // (R13) (R14)
            assign rt.pin_drv[g] = (hits(rt.rx_sel, g) & rt.rx_sop)
                | (hits(rt.tx_sel, g) & rt.tx_sop); // (R13) (R14)
        end
    endgenerate
endmodule

/* File: logic/phy_system_config_registers.sv */
// system configuration register bank of the single-pair PHY
//
// Notes on behaviour
// (R01) bank lives at management device 0x1E
// (R02) host leaves MAC interface configuration alone
// (R03) bit 15 shows RMII reference clock rate
// (R04) bit 14 shows RMII clock generation enabled
// (R05) bit 8 enables media converter, RMII only
// (R06) RMII and RGMII enables never both set
// (R07) diag clock enable bit 0, register resets 0x0002
// (R08) read-only six-bit package type code
// (R09) group mode accepts writes to port 31
// (R10) host clears group mode after initialisation
// (R11) indicator B route: 000 on, 111 off
// (R12) link status polarity bit, reset high-active
// (R13) receive packet start routed to one pin
// (R14) transmit packet start same mapping, reset off
// (R15) pin mux registers reset 0x00FE and 0x00FF
// (R16) reserved bits ignore writes, read fixed values
`timescale 1ns/100ps
`include "phy_syscfg_cfg.svh"
module phy_system_config_registers
    import phy_syscfg_pkg::*;
#(
    parameter logic [5:0] PACKAGE_CODE = 6'h15, // arbitrary neutral value
    parameter int PINS = `ROUTE_PINS
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // management register access
    input wire logic i_mgmt_rd,
    input wire logic i_mgmt_wr,
    input wire logic [4:0] i_mgmt_devad,
    input wire logic [15:0] i_mgmt_regaddr,
    input wire logic [15:0] i_mgmt_wdata,
    output logic o_mgmt_ready,
    output logic o_mgmt_ack,
    output logic [15:0] o_mgmt_rdata,
    // management frame port address check
    input wire logic [4:0] i_own_port_addr,
    input wire logic [4:0] i_frame_port_addr,
    input wire logic i_frame_is_wr_or_addr,
    output logic o_port_accept,
    // straps sampled once after reset
    input wire logic i_strap_rmii_refclk_rate_sel,
    input wire logic i_strap_rmii_clock_gen_on,
    input wire logic i_strap_media_converter_on,
    input wire logic i_strap_reduced_mii_mode_on,
    input wire logic i_strap_reduced_gigabit_mii_mode_on,
    // internal events and indicator sources
    input wire logic i_link_up,
    input wire logic i_indicator_b,
    input wire logic i_rx_packet_start,
    input wire logic i_tx_packet_start,
    // configuration outputs
    output logic o_rmii_refclk_rate_sel,
    output logic o_rmii_clock_gen_on,
    output logic o_media_converter_on,
    output logic o_reduced_mii_mode_on,
    output logic o_reduced_gigabit_mii_mode_on,
    output logic o_diagnostics_clock_on,
    output logic o_group_address_mode_on,
    // pins
    output logic o_link_status_pin,
    output logic o_indicator_pin_b,
    output logic o_indicator_pin_b_en,
    output logic [14:0] o_packet_start_indicator,
    output logic [14:0] o_packet_start_indicator_en
);
    // ==========================================================
    // state of the bank, one packed word
    typedef struct packed {
        acc_state_t fsm; // access sequencer
        logic ack; // answer strobe
        logic [15:0] rdata; // read answer
        logic strap_done; // straps already captured
        logic clk50; // rmii reference clock rate
        logic clkgen; // rmii clock generation
        logic media; // media converter request
        logic rmii; // rmii mode
        logic rgmii; // rgmii mode
        logic diag; // diagnostics clock
        logic grp; // group address mode
        logic [2:0] ledb_sel; // indicator b route
        logic pol; // link status polarity
        route_code_t rx_sel; // receive start route
        route_code_t tx_sel; // transmit start route
        logic link_out; // registered link status pin
        logic ledb_out; // registered indicator b pin
        logic ledb_en; // indicator b driven
        pin_vec_t pin_drv; // registered packet start pins
        pin_vec_t pin_en; // registered packet start enables
    } state_t;

    // reset image, pin mux fields at their off codes
    localparam state_t RESET_STATE = '{
        fsm: ST_IDLE,
        ledb_sel: 3'(`PMA_RESET >> `PMA_LEDB_LO),
        rx_sel: route_code_t'(`PMB_RESET >> `PMB_RX_LO),
        tx_sel: route_code_t'(`PMB_RESET >> `PMB_TX_LO),
        default: '0
    };

    state_t s_r; // registered state
    state_t s_nxt; // next state
    logic rst_meta_r; // reset release, first stage
    logic rst_sync_r; // reset release, used everywhere
    logic take; // request accepted this cycle

    // ==========================================================
    // reset release through two flops
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // ==========================================================
    // pin route decoder
    route_if rt ();
    assign rt.rx_sel = s_r.rx_sel;
    assign rt.tx_sel = s_r.tx_sel;
    assign rt.rx_sop = i_rx_packet_start;
    assign rt.tx_sop = i_tx_packet_start;

    pin_route_decoder #(
        .PINS(PINS)
    ) u_route (
        .rt(rt)
    );

    // ==========================================================
    // read-back of every register; reserved bits are constants
    function automatic logic [15:0] read_word(input logic [15:0] addr, input state_t s);
        logic [15:0] w;
        w = 16'h0000;
        case (addr) // (R01)
            `ADDR_MAC_CFG: begin
                w[`MAC_CLK50_BIT] = s.clk50; // (R03)
                w[`MAC_CLKGEN_BIT] = s.clkgen; // (R04)
                w[`MAC_MEDIA_BIT] = s.media;
                w[`MAC_RMII_BIT] = s.rmii;
                w[`MAC_RGMII_BIT] = s.rgmii;
            end
            `ADDR_DIAG_CLK: begin
                w = `DIAG_RESET; // (R07) (R16)
                w[`DIAG_EN_BIT] = s.diag;
            end
            `ADDR_PKG_TYPE: begin
                w[5:0] = PACKAGE_CODE; // (R08)
            end
            `ADDR_GRP_CTRL: begin
                w[`GRP_EN_BIT] = s.grp;
            end
            `ADDR_PINMUX_A: begin
                w = `PMA_RSVD; // (R16)
                w[`PMA_LEDB_HI:`PMA_LEDB_LO] = s.ledb_sel;
                w[`PMA_POL_BIT] = s.pol;
            end
            `ADDR_PINMUX_B: begin
                w[`PMB_RX_HI:`PMB_RX_LO] = s.rx_sel;
                w[`PMB_TX_HI:`PMB_TX_LO] = s.tx_sel;
            end
            // unmapped address inside the device reads zero
            default: begin
                w = 16'h0000;
            end
        endcase
        read_word = w;
    endfunction

    // only frames for this management device are served
    assign take = (s_r.fsm == ST_IDLE) && (i_mgmt_rd || i_mgmt_wr)
        && (i_mgmt_devad == `MGMT_DEVAD); // (R01)

    // ==========================================================
    // next-state logic
    always_comb begin
        s_nxt = s_r;
        s_nxt.ack = 1'b0;
        // straps land on the first edge after release
        if (!s_r.strap_done) begin
            s_nxt.strap_done = 1'b1;
            s_nxt.clk50 = i_strap_rmii_refclk_rate_sel; // (R03)
            s_nxt.clkgen = i_strap_rmii_clock_gen_on; // (R04)
            s_nxt.media = i_strap_media_converter_on;
            // a bad strap pair leaves both modes off
            if (!(i_strap_reduced_mii_mode_on && i_strap_reduced_gigabit_mii_mode_on)) begin
                s_nxt.rmii = i_strap_reduced_mii_mode_on; // (R06)
                s_nxt.rgmii = i_strap_reduced_gigabit_mii_mode_on; // (R06)
            end
        end
        case (s_r.fsm)
            ST_IDLE: begin
                if (take) begin
                    s_nxt.fsm = ST_ACK;
                    s_nxt.ack = 1'b1;
                    // a read answers with the value before any write
                    s_nxt.rdata = i_mgmt_rd ? read_word(i_mgmt_regaddr, s_r) : 16'h0000;
                    if (i_mgmt_wr) begin
                        case (i_mgmt_regaddr)
                            `ADDR_MAC_CFG: begin
                                // kept writable for debug, host should not touch it (R02)
                                s_nxt.clk50 = i_mgmt_wdata[`MAC_CLK50_BIT]; // (R03)
                                s_nxt.clkgen = i_mgmt_wdata[`MAC_CLKGEN_BIT]; // (R04)
                                s_nxt.media = i_mgmt_wdata[`MAC_MEDIA_BIT]; // (R05)
                                // both modes at once is refused, modes stay as they were
                                if (!(i_mgmt_wdata[`MAC_RMII_BIT]
                                        && i_mgmt_wdata[`MAC_RGMII_BIT])) begin
                                    s_nxt.rmii = i_mgmt_wdata[`MAC_RMII_BIT]; // (R06)
                                    s_nxt.rgmii = i_mgmt_wdata[`MAC_RGMII_BIT]; // (R06)
                                end
                            end
                            `ADDR_DIAG_CLK: begin
                                s_nxt.diag = i_mgmt_wdata[`DIAG_EN_BIT]; // (R07)
                            end
                            `ADDR_GRP_CTRL: begin
                                // the host is trusted to clear this after bring-up (R10)
                                s_nxt.grp = i_mgmt_wdata[`GRP_EN_BIT];
                            end
                            `ADDR_PINMUX_A: begin
                                s_nxt.ledb_sel = i_mgmt_wdata[`PMA_LEDB_HI:`PMA_LEDB_LO]; // (R11)
                                s_nxt.pol = i_mgmt_wdata[`PMA_POL_BIT]; // (R12)
                            end
                            `ADDR_PINMUX_B: begin
                                s_nxt.rx_sel = i_mgmt_wdata[`PMB_RX_HI:`PMB_RX_LO]; // (R13)
                                s_nxt.tx_sel = i_mgmt_wdata[`PMB_TX_HI:`PMB_TX_LO]; // (R14)
                            end
                            // package register and unmapped addresses ignore writes
                            default: begin
                                s_nxt.rdata = s_nxt.rdata; // (R08) (R16)
                            end
                        endcase
                    end
                end
            end
            ST_ACK: begin
                // one idle cycle between answers keeps the strobe a pulse
                s_nxt.fsm = ST_IDLE;
            end
            default: begin
                s_nxt.fsm = ST_IDLE;
            end
        endcase
        // pin outputs, one cycle behind their sources
        s_nxt.link_out = i_link_up ^ s_r.pol; // (R12)
        // only code 000 routes the indicator; other codes leave it off
        s_nxt.ledb_en = (s_r.ledb_sel == `LEDB_ROUTE_ON); // (R11)
        s_nxt.ledb_out = s_nxt.ledb_en & i_indicator_b; // (R11)
        s_nxt.pin_drv = rt.pin_drv; // (R13) (R14)
        s_nxt.pin_en = rt.pin_en; // (R13) (R14)
    end

    // ==========================================================
    // state register
    always_ff @(posedge i_clock or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            s_r <= RESET_STATE; // (R15)
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // outputs
    assign o_mgmt_ready = (s_r.fsm == ST_IDLE);
    assign o_mgmt_ack = s_r.ack;
    assign o_mgmt_rdata = s_r.rdata;
    // group mode widens acceptance to port 31 for writes and address frames
    assign o_port_accept = (i_frame_port_addr == i_own_port_addr)
        || (s_r.grp && i_frame_is_wr_or_addr
            && (i_frame_port_addr == `GROUP_PORT_ADDR)); // (R09)
    assign o_rmii_refclk_rate_sel = s_r.clk50;
    assign o_rmii_clock_gen_on = s_r.clkgen;
    // media converter never acts outside rmii mode
    assign o_media_converter_on = s_r.media & s_r.rmii; // (R05)
    assign o_reduced_mii_mode_on = s_r.rmii;
    assign o_reduced_gigabit_mii_mode_on = s_r.rgmii;
    assign o_diagnostics_clock_on = s_r.diag;
    assign o_group_address_mode_on = s_r.grp;
    assign o_link_status_pin = s_r.link_out;
    assign o_indicator_pin_b = s_r.ledb_out;
    assign o_indicator_pin_b_en = s_r.ledb_en;
    assign o_packet_start_indicator = s_r.pin_drv;
    assign o_packet_start_indicator_en = s_r.pin_en;

    // ==========================================================
    // checks
    a_ack_after_take: assert property (@(posedge i_clock) disable iff (!rst_sync_r)
        take |=> o_mgmt_ack ##1 !o_mgmt_ack) // (R01)
        else $error("request not answered in one cycle");
    a_foreign_devad: assert property (@(posedge i_clock) disable iff (!rst_sync_r)
        (o_mgmt_ready && i_mgmt_rd && i_mgmt_devad != `MGMT_DEVAD) |=> !o_mgmt_ack) // (R01)
        else $error("answer to another management device");
    a_modes_exclusive: assert property (@(posedge i_clock) disable iff (!rst_sync_r)
        !(o_reduced_mii_mode_on && o_reduced_gigabit_mii_mode_on)) // (R06)
        else $error("both interface modes enabled");
    a_media_gated: assert property (@(posedge i_clock) disable iff (!rst_sync_r)
        o_media_converter_on |-> o_reduced_mii_mode_on) // (R05)
        else $error("media converter outside rmii mode");
    a_diag_write: assert property (@(posedge i_clock) disable iff (!rst_sync_r)
        (take && i_mgmt_wr && i_mgmt_regaddr == `ADDR_DIAG_CLK)
        |=> o_diagnostics_clock_on == $past(i_mgmt_wdata[`DIAG_EN_BIT])) // (R07)
        else $error("diagnostics clock enable not written");
    a_diag_readback: assert property (@(posedge i_clock) disable iff (!rst_sync_r)
        (take && i_mgmt_rd && !i_mgmt_wr && i_mgmt_regaddr == `ADDR_DIAG_CLK)
        |=> o_mgmt_rdata == (`DIAG_RESET | {15'h0000, o_diagnostics_clock_on})) // (R07)
        else $error("diagnostics register reads wrong");
    a_pkg_readback: assert property (@(posedge i_clock) disable iff (!rst_sync_r)
        (take && i_mgmt_rd && i_mgmt_regaddr == `ADDR_PKG_TYPE)
        |=> o_mgmt_rdata == {10'h000, PACKAGE_CODE}) // (R08)
        else $error("package code reads wrong");
    a_group_accept: assert property (@(posedge i_clock) disable iff (!rst_sync_r)
        (o_group_address_mode_on && i_frame_is_wr_or_addr
            && i_frame_port_addr == `GROUP_PORT_ADDR) |-> o_port_accept) // (R09)
        else $error("group address frame refused");
    a_link_polarity: assert property (@(posedge i_clock) disable iff (!rst_sync_r)
        $past(rst_sync_r) |-> o_link_status_pin == ($past(i_link_up) ^ $past(s_r.pol))) // (R12)
        else $error("link status polarity wrong");
    a_ledb_off: assert property (@(posedge i_clock) disable iff (!rst_sync_r)
        (s_r.ledb_sel == `LEDB_ROUTE_OFF) |=> !o_indicator_pin_b_en) // (R11)
        else $error("indicator b driven while off");
    a_route_off: assert property (@(posedge i_clock) disable iff (!rst_sync_r)
        (s_r.rx_sel == `ROUTE_OFF && s_r.tx_sel == `ROUTE_OFF)
        |=> o_packet_start_indicator_en == '0) // (R13) (R14)
        else $error("packet start pin driven while off");
    a_pmb_after_reset: assert property (@(posedge i_clock)
        $rose(rst_sync_r) |-> {s_r.rx_sel, s_r.tx_sel} == `PMB_RESET) // (R15)
        else $error("pin mux b reset value wrong");
    a_pma_readback: assert property (@(posedge i_clock) disable iff (!rst_sync_r)
        (take && i_mgmt_rd && i_mgmt_regaddr == `ADDR_PINMUX_A)
        |=> o_mgmt_rdata[15:4] == `PMA_RSVD >> 4) // (R16)
        else $error("pin mux a reserved bits disturbed");
endmodule

/* File: test/mgmt_host_model.sv */
// management host model driving the register request port
`timescale 1ns/100ps
module mgmt_host_model (
    // clock
    input wire logic i_clock,
    // answers from the bank
    input wire logic i_mgmt_ready,
    input wire logic i_mgmt_ack,
    input wire logic [15:0] i_mgmt_rdata,
    // requests to the bank
    output logic o_mgmt_rd,
    output logic o_mgmt_wr,
    output logic [4:0] o_mgmt_devad,
    output logic [15:0] o_mgmt_regaddr,
    output logic [15:0] o_mgmt_wdata
);
    // ==========================================================
    // idle request lines
    initial begin
        o_mgmt_rd = 1'b0;
        o_mgmt_wr = 1'b0;
        o_mgmt_devad = 5'h00;
        o_mgmt_regaddr = 16'h0000;
        o_mgmt_wdata = 16'h0000;
    end
    // ==========================================================
    // one access; request held through the edge after ready is seen, answer read at settle point
    // mac config writes only come from debug scenarios
    task automatic access(input logic [4:0] devad, input logic wr, input logic [15:0] addr,
                          input logic [15:0] wd, output logic [15:0] rdata, output logic acked);
        int n;
        @(negedge i_clock);
        o_mgmt_devad = devad;
        o_mgmt_regaddr = addr;
        o_mgmt_wdata = wr ? wd : ~wd; // no stale data on a read
        o_mgmt_rd = !wr;
        o_mgmt_wr = wr;
        n = 0;
        // ready seen settled before the taking edge
        while (i_mgmt_ready !== 1'b1 && n < 8) begin
            @(negedge i_clock);
            n++;
        end
        @(negedge i_clock);
        acked = (i_mgmt_ack === 1'b1);
        rdata = i_mgmt_rdata;
        // released after the answer; ready is low so no re-take
        o_mgmt_rd = 1'b0;
        o_mgmt_wr = 1'b0;
        o_mgmt_regaddr = ~addr;
    endtask
endmodule

/* File: test/phy_system_config_registers_tb_top.sv */
// self-checking bench for the system config register bank
`timescale 1ns/100ps
module phy_system_config_registers_tb_top;
    import phy_syscfg_pkg::*;
    // ==========================================================
    // signals
    logic clock, resetn, rd, wr, ready, ack, accept, frame_wr;
    logic [4:0] devad, own_port, frame_port;
    logic [15:0] regaddr, wdata, rdata, got;
    logic [4:0] straps; // clk50, clkgen, media, rmii, rgmii
    logic link_up, ind_b, rx_sop, tx_sop, ok;
    logic clk50, clkgen, media, rmii, rgmii, diag, grp, link_pin, pin_b, pin_b_en;
    logic [14:0] sop_drv, sop_en;
    int miscompares = 0;
    int checks_done = 0;
    // ==========================================================
    // clock, reset and time-zero inputs
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    initial begin
        resetn = 1'b0;
        straps = 5'b10110;
        own_port = 5'h03;
        frame_port = 5'h1F;
        frame_wr = 1'b1;
        {link_up, ind_b, rx_sop, tx_sop} = 4'h0;
        repeat (20) @(negedge clock);
        resetn = 1'b1;
    end
    // ==========================================================
    // units
    mgmt_host_model host (.i_clock(clock), .i_mgmt_ready(ready), .i_mgmt_ack(ack),
        .i_mgmt_rdata(rdata), .o_mgmt_rd(rd), .o_mgmt_wr(wr), .o_mgmt_devad(devad),
        .o_mgmt_regaddr(regaddr), .o_mgmt_wdata(wdata));
    phy_system_config_registers DUT (.i_clock(clock), .i_resetn(resetn), .i_mgmt_rd(rd),
        .i_mgmt_wr(wr), .i_mgmt_devad(devad), .i_mgmt_regaddr(regaddr), .i_mgmt_wdata(wdata),
        .o_mgmt_ready(ready), .o_mgmt_ack(ack), .o_mgmt_rdata(rdata),
        .i_own_port_addr(own_port), .i_frame_port_addr(frame_port),
        .i_frame_is_wr_or_addr(frame_wr), .o_port_accept(accept),
        .i_strap_rmii_refclk_rate_sel(straps[4]), .i_strap_rmii_clock_gen_on(straps[3]),
        .i_strap_media_converter_on(straps[2]), .i_strap_reduced_mii_mode_on(straps[1]),
        .i_strap_reduced_gigabit_mii_mode_on(straps[0]), .i_link_up(link_up),
        .i_indicator_b(ind_b), .i_rx_packet_start(rx_sop), .i_tx_packet_start(tx_sop),
        .o_rmii_refclk_rate_sel(clk50), .o_rmii_clock_gen_on(clkgen),
        .o_media_converter_on(media), .o_reduced_mii_mode_on(rmii),
        .o_reduced_gigabit_mii_mode_on(rgmii), .o_diagnostics_clock_on(diag),
        .o_group_address_mode_on(grp), .o_link_status_pin(link_pin),
        .o_indicator_pin_b(pin_b), .o_indicator_pin_b_en(pin_b_en),
        .o_packet_start_indicator(sop_drv), .o_packet_start_indicator_en(sop_en));
    // ==========================================================
    // compare, register access and verdict
    task automatic check(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rw(input logic w, input logic [15:0] a, input logic [15:0] d);
        host.access(5'h1E, w, a, d, got, ok);
        check({15'h0, ok}, 16'h0001);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ==========================================================
    // reset image, straps and unmapped read
    task automatic t_reset();
        rw(0, 16'h882B, 0); check(got, 16'h8110);
        check({11'h0, clk50, clkgen, media, rmii, rgmii}, 16'h0016);
        rw(0, 16'h882C, 0); check(got, 16'h0002);
        rw(0, 16'h8C22, 0); check(got, 16'h0015);
        rw(0, 16'h8C30, 0); check(got, 16'h0000);
        rw(0, 16'h8C56, 0); check(got, 16'h00FE);
        rw(0, 16'h8C57, 0); check(got, 16'h00FF);
        rw(0, 16'h8C00, 0); check(got, 16'h0000);
        host.access(5'h01, 0, 16'h882B, 0, got, ok); check({15'h0, ok}, 16'h0000);
        $display("reset image test done");
    endtask
    // ==========================================================
    // writes against reserved and read-only bits, mode exclusion
    task automatic t_writes();
        rw(1, 16'h882C, 16'hFFFF); rw(0, 16'h882C, 0); check(got, 16'h0003);
        check({15'h0, diag}, 16'h0001);
        rw(1, 16'h8C22, 16'hFFFF); rw(0, 16'h8C22, 0); check(got, 16'h0015);
        rw(1, 16'h882B, 16'h0111); rw(0, 16'h882B, 0); check(got, 16'h0110);
        rw(1, 16'h882B, 16'h0101); rw(0, 16'h882B, 0); check(got, 16'h0101);
        check({14'h0, media, rgmii}, 16'h0001);
        $display("register write test done");
    endtask
    // ==========================================================
    // group address widening of frame acceptance
    task automatic t_group();
        #1 check({14'h0, grp, accept}, 16'h0000);
        rw(1, 16'h8C30, 16'h0001);
        #1 check({14'h0, grp, accept}, 16'h0003);
        @(negedge clock);
        frame_wr = 1'b0;
        #1 check({15'h0, accept}, 16'h0000);
        // own address is always accepted, whatever the frame kind
        @(negedge clock);
        frame_port = own_port;
        #1 check({15'h0, accept}, 16'h0001);
        @(negedge clock);
        frame_port = 5'h1F;
        frame_wr = 1'b1;
        rw(1, 16'h8C30, 16'h0000); // cleared after init
        #1 check({14'h0, grp, accept}, 16'h0000);
        $display("group address test done");
    endtask
    // ==========================================================
    // indicator, polarity and packet start routing per code
    task automatic t_pins();
        @(negedge clock);
        link_up = 1'b1;
        ind_b = 1'b1;
        @(negedge clock); check({13'h0, link_pin, pin_b, pin_b_en}, 16'h0004);
        rw(1, 16'h8C56, 16'hFF01); rw(0, 16'h8C56, 0); check(got, 16'h00F1);
        check({13'h0, link_pin, pin_b, pin_b_en}, 16'h0003);
        rx_sop = 1'b1;
        tx_sop = 1'b1;
        for (int i = 0; i < 15; i++) begin
            rw(1, 16'h8C57, {8'h0, i[3:0], 4'hF});
            @(negedge clock); check({sop_en, 1'b0}, 16'h0002 << i);
            check({sop_drv, 1'b0}, 16'h0002 << i);
            rw(1, 16'h8C57, {8'h0, 4'hF, i[3:0]});
            @(negedge clock); check({sop_drv, 1'b0}, 16'h0002 << i);
        end
        rw(1, 16'h8C57, 16'h00FF);
        @(negedge clock); check({sop_en, 1'b0}, 16'h0000);
        $display("pin route test done");
    endtask
    // ==========================================================
    // main sequence and watchdog
    initial begin
        wait (resetn === 1'b1);
        repeat (4) @(negedge clock);
        t_reset();
        t_writes();
        t_group();
        t_pins();
        report_and_stop();
    end
    initial begin
        #200000;
        miscompares++;
        report_and_stop();
    end
endmodule
